// ### actc_defines.svh
// Constants of the converter clock and trigger control: register indices,
// field positions, reset values and sequencer counts.
// Assumes it is included by bare name wherever the numbers are needed.
`ifndef ACTC_DEFINES_SVH
`define ACTC_DEFINES_SVH

// Register indices; the byte address on the bus is four times the index.
`define ACTC_IDX_PORT_A_PINS       10'h005
`define ACTC_IDX_INTERRUPT_CONTROL 10'h00b
`define ACTC_IDX_PERIPH_FLAGS_ONE  10'h00c
`define ACTC_IDX_CONV_RESULT       10'h01e
`define ACTC_IDX_CONV_CTRL_MAIN    10'h01f
`define ACTC_IDX_PORT_A_DIRECTION  10'h085
`define ACTC_IDX_PERIPH_EN_ONE     10'h08c
`define ACTC_IDX_CONV_PIN_CONFIG   10'h09f

// Reset values.
`define ACTC_RST_CTRL_MAIN   8'h00
`define ACTC_RST_PIN_CONFIG  3'h0
`define ACTC_RST_DIRECTION   6'h3f
`define ACTC_RST_PORT_LATCH  6'h00
`define ACTC_RST_INT_CTRL    8'h00
`define ACTC_RST_FLAGS       8'h00
`define ACTC_RST_ENABLES     8'h00
`define ACTC_RST_RESULT      8'h00

// Field positions in the flag and enable registers.
`define ACTC_BIT_DONE_FLAG   6
`define ACTC_BIT_TRIG_FLAG   2

// Compare mode code that requests the special event trigger.
`define ACTC_TRIG_MODE       4'hb

// Half conversion-clock periods, in core clocks, per select code.
`define ACTC_HALF_DIV2       6'h01
`define ACTC_HALF_DIV8       6'h04
`define ACTC_HALF_DIV32      6'h10

// Sequencer: 9.5 periods make 19 half periods; decisions at 3,5..17.
`define ACTC_HALF_TOTAL      5'h13
`define ACTC_HALF_FIRST_DEC  5'h03
`define ACTC_HALF_LAST_DEC   5'h11
`define ACTC_CODE_START      8'h80

`endif

// ### actc_front_model.sv
// Analog front end and port pins of the converter control.
// Assumes a one-hot channel select.
`timescale 1ns/1ps
module actc_front_model (
  // Design side.
  input  wire logic [7:0]      dac_code,
  input  wire logic [3:0]      chan_sel,
  input  wire logic [5:0]      port_out,
  input  wire logic [5:0]      port_oe,
  // Bench side.
  input  wire logic [3:0][7:0] level,
  // Answers.
  output logic                 cmp_above,
  output logic [5:0]           port_in
);
  logic [3:0][7:0] seen; // Level on each channel.

  // Ideal comparator, settled at once, so short periods resolve here.
  always_comb
  begin
    cmp_above = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      seen[i] = port_oe[i] ? {8{port_out[i]}} : level[i];
      if (chan_sel[i])
        cmp_above = seen[i] >= dac_code;
    end
    // Undriven pins 4 and 5 rest high on pull-ups.
    port_in = {port_out[5:4] | ~port_oe[5:4], seen[3][7], seen[2][7],
               seen[1][7], seen[0][7]};
  end
endmodule : actc_front_model

// ### actc_monitor.sv
// Checker of the converter control, on the top module's ports.
// Assumes binding to actc_top on the core clock.
`timescale 1ns/1ps
module actc_monitor (
  // Clock and reset.
  input wire logic        I_CORE_CLK,
  input wire logic        I_RST_N,
  // Bus.
  input wire logic        I_PSEL,
  input wire logic        I_PENABLE,
  input wire logic        I_PWRITE,
  input wire logic [11:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic        O_PREADY,
  input wire logic        O_PSLVERR,
  // Pins and converter.
  input wire logic [5:0]  O_PORT_A_OE,
  input wire logic [3:0]  I_COMPARE_MODE,
  input wire logic        I_SPECIAL_TRIG,
  input wire logic        O_TIMER_CLEAR,
  input wire logic [7:0]  O_DAC_CODE,
  input wire logic [3:0]  O_CHANNEL_SEL,
  input wire logic        O_SAMPLE,
  input wire logic        O_CONV_ENABLE
);
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RST_N);
  logic        wr;                // A write is taken at this edge.
  logic [1:0]  sel_reg, sel_next; // Clock select last written.
  logic [10:0] low_reg, low_next; // Cycles converting so far.
  int          exp_len;           // Nominal length in core clocks.
  ////////////////////////////////////////////////////////////////////////
  // Helper state; the length count clears when idle.
  always_comb
  begin
    wr       = I_PSEL && I_PENABLE && I_PWRITE;
    sel_next = (wr && I_PADDR == 12'h07c) ? I_PWDATA[7:6] : sel_reg;
    low_next = (O_CONV_ENABLE && !O_SAMPLE) ? low_reg + 11'h001 : 11'h000;
    exp_len  = 19 << (2 * sel_reg);
  end
  always_ff @(posedge I_CORE_CLK)
  begin
    sel_reg <= I_RST_N ? sel_next : 2'h0;
    low_reg <= I_RST_N ? low_next : 11'h000;
  end
  ////////////////////////////////////////////////////////////////////////
  sequence s_conv_end;
    $rose(O_SAMPLE) && low_reg != 11'h000 && sel_reg != 2'h3;
  endsequence
  property p_len;
    s_conv_end |-> low_reg >= exp_len - 2 && low_reg <= exp_len + 2;
  endproperty
  a_len: assert property (p_len)
    else $error("conversion length wrong");
  property p_ready;
    I_PSEL && I_PENABLE |-> O_PREADY;
  endproperty
  a_ready: assert property (p_ready) else $error("no ready");
  property p_err;
    O_PSLVERR |-> I_PSEL && I_PENABLE && I_PADDR != 12'h07c;
  endproperty
  a_err: assert property (p_err) else $error("stray slave error");
  property p_tclr;
    O_TIMER_CLEAR == $past(I_SPECIAL_TRIG);
  endproperty
  a_tclr: assert property (p_tclr)
    else $error("timer clear wrong");
  property p_trig_start;
    I_SPECIAL_TRIG && I_COMPARE_MODE == 4'hb && O_SAMPLE |-> ##[1:3] !O_SAMPLE;
  endproperty
  a_trig_start: assert property (p_trig_start)
    else $error("trigger did not start");
  property p_trig_other;
    I_SPECIAL_TRIG && I_COMPARE_MODE != 4'hb && O_SAMPLE && !I_PSEL
      |=> O_SAMPLE [*3];
  endproperty
  a_trig_other: assert property (p_trig_other)
    else $error("trigger started in wrong mode");
  property p_first_trial;
    $fell(O_SAMPLE) && O_CONV_ENABLE |-> ##[0:1] O_DAC_CODE == 8'h80;
  endproperty
  a_first_trial: assert property (p_first_trial)
    else $error("first trial code wrong");
  property p_oe;
    wr && I_PADDR == 12'h214 |=> O_PORT_A_OE == ~$past(I_PWDATA[5:0]);
  endproperty
  a_oe: assert property (p_oe) else $error("pin enable wrong");
  property p_chan;
    wr && I_PADDR == 12'h07c |=> O_CHANNEL_SEL ==
      ($past(I_PWDATA[5]) ? 4'h0 : 4'h1 << $past(I_PWDATA[4:3]));
  endproperty
  a_chan: assert property (p_chan)
    else $error("channel decode wrong");
endmodule : actc_monitor

bind actc_top actc_monitor u_mon (.*);

// ### actc_pkg.sv
// Types of the converter clock and trigger control.
// Assumes nothing beyond a SystemVerilog compiler.
package actc_pkg;

  // Layout of the main converter control register, bit 7 first.
  typedef struct packed {
    logic [1:0] conv_clock_select;    // Conversion clock source.
    logic [2:0] input_channel_select; // Analog channel number.
    logic       go;                   // Conversion in progress.
    logic       reserved;             // Kept as written.
    logic       converter_on;         // Module enable.
  } actc_ctrl_s;

  // Sequencer states.
  typedef enum logic [0:0] {
    ACTC_IDLE,
    ACTC_CONVERT
  } actc_state_e;

endpackage : actc_pkg

// ### actc_sar_seq.sv
// Successive-approximation sequencer, MSB first, 19 half periods long.
// Assumes an asynchronous comparator, synchronised here.
`timescale 1ns/1ps
`include "actc_defines.svh"
module actc_sar_seq
  import actc_pkg::*;
(
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Control.
  input  wire logic       start,
  input  wire logic       abort,
  input  wire logic       half_tick,
  input  wire logic       cmp_above,
  // Status and data.
  output logic            busy,
  output logic            done,
  output logic [7:0]      code
);
  actc_state_e state_reg, state_next; // Sequencer state.
  logic [4:0]  half_reg, half_next;   // Half periods elapsed.
  logic [7:0]  code_reg, code_next;   // Trial and final code.
  logic        cmp_s1_reg, cmp_s2_reg; // Comparator synchroniser.
  logic [4:0]  dec;                   // Decision number.
  logic [2:0]  bit_idx;               // Bit being decided.

  // Next state; abort wins over everything and keeps the partial code.
  always_comb
  begin
    state_next = state_reg;
    half_next  = half_reg;
    code_next  = code_reg;
    done       = 1'b0;
    dec        = (half_reg + 5'h01 - `ACTC_HALF_FIRST_DEC) >> 1;
    bit_idx    = 3'h7 - dec[2:0];
    unique case (state_reg)
      ACTC_IDLE:
      begin
        if (start && !abort)
        begin
          state_next = ACTC_CONVERT;
          half_next  = 5'h00;
          code_next  = `ACTC_CODE_START;
        end
      end
      ACTC_CONVERT:
      begin
        if (abort)
        begin
          state_next = ACTC_IDLE;
        end
        else if (half_tick)
        begin
          half_next = half_reg + 5'h01;
          if (half_next[0] && half_next >= `ACTC_HALF_FIRST_DEC
              && half_next <= `ACTC_HALF_LAST_DEC)
          begin
            code_next[bit_idx] = cmp_s2_reg;
            if (bit_idx != 3'h0)
            begin
              code_next[bit_idx - 3'h1] = 1'b1;
            end
          end
          if (half_next == `ACTC_HALF_TOTAL)
          begin
            state_next = ACTC_IDLE;
            done       = 1'b1;
          end
        end
      end
    endcase
  end

  assign busy = (state_reg == ACTC_CONVERT);
  assign code = code_reg;

  // Registers.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_reg  <= ACTC_IDLE;
      half_reg   <= 5'h00;
      code_reg   <= 8'h00;
      cmp_s1_reg <= 1'b0;
      cmp_s2_reg <= 1'b0;
    end
    else
    begin
      state_reg  <= state_next;
      half_reg   <= half_next;
      code_reg   <= code_next;
      cmp_s1_reg <= cmp_above;
      cmp_s2_reg <= cmp_s1_reg;
    end
  end
endmodule : actc_sar_seq

// ### actc_tick_gen.sv
// Half-period tick generator for the conversion clock.
// Assumes an asynchronous RC oscillator, synchronised here.
`timescale 1ns/1ps
`include "actc_defines.svh"
module actc_tick_gen
  import actc_pkg::*;
(
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Control.
  input  wire logic       run,
  input  wire logic [1:0] sel,
  input  wire logic       rc_osc,
  // Tick output.
  output logic            half_tick
);
  logic [5:0] div_reg, div_next;   // Core clocks since the last tick.
  logic       rc_s1_reg, rc_s2_reg; // Two-stage synchroniser.
  logic       rc_d_reg;             // Previous synchronised level.
  logic [5:0] half_len;             // Half period for the select code.

  // Divider length per select; code 11 uses the RC edges instead.
  always_comb
  begin
    unique case (sel)
      2'b00: half_len = `ACTC_HALF_DIV2;
      2'b01: half_len = `ACTC_HALF_DIV8;
      default: half_len = `ACTC_HALF_DIV32;
    endcase
  end

  // Each edge of the RC source is a half period; divider restarts idle.
  always_comb
  begin
    div_next  = 6'h00;
    half_tick = 1'b0;
    if (run && sel == 2'b11)
    begin
      half_tick = rc_d_reg ^ rc_s2_reg;
    end
    else if (run)
    begin
      div_next = div_reg + 6'h01;
      if (div_next == half_len)
      begin
        half_tick = 1'b1;
        div_next  = 6'h00;
      end
    end
  end

  // Registers; the first synchroniser stage feeds only the second.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      div_reg   <= 6'h00;
      rc_s1_reg <= 1'b0;
      rc_s2_reg <= 1'b0;
      rc_d_reg  <= 1'b0;
    end
    else
    begin
      div_reg   <= div_next;
      rc_s1_reg <= rc_osc;
      rc_s2_reg <= rc_s1_reg;
      rc_d_reg  <= rc_s2_reg;
    end
  end
endmodule : actc_tick_gen

// ### actc_top.sv
// Converter clock and trigger control: APB registers, port pin logic,
// conversion clock, sequencer and special event trigger.
// Assumes an APB master on the core clock, an on-chip compare unit on the
// same clock and an analog front end driven by the code and channel lines.
//
// Contract
// - Conversion lasts nine and a half clock periods.
// - Select gives 2, 8, 32 clocks or RC.
// - Output pins still convert their driven level.
// - Analog channel pins read zero in port.
// - Digital input pins still convert normally.
// - Trigger in mode 1011 starts when on.
// - Every trigger clears the sixteen-bit timer.
// - Trigger ignored when off, timer still cleared.
// - Completion loads result, clears go, sets flag.
// - Channel codes 0-3 select inputs; others reserved.
// - Reset restores controls, stops converter, aborts conversion.
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
`include "actc_defines.svh"
module actc_top
  import actc_pkg::*;
(
  // Clock and reset.
  input  wire logic        I_CORE_CLK,
  input  wire logic        I_RST_N,
  // APB slave.
  input  wire logic        I_PSEL,
  input  wire logic        I_PENABLE,
  input  wire logic        I_PWRITE,
  input  wire logic [11:0] I_PADDR,
  input  wire logic [31:0] I_PWDATA,
  output logic      [31:0] O_PRDATA,
  output logic             O_PREADY,
  output logic             O_PSLVERR,
  // Port A pins, split into input, output and output enable.
  input  wire logic [5:0]  I_PORT_A,
  output logic      [5:0]  O_PORT_A,
  output logic      [5:0]  O_PORT_A_OE,
  // Internal RC oscillator for the conversion clock.
  input  wire logic        I_RC_OSC,
  // Compare unit.
  input  wire logic [3:0]  I_COMPARE_MODE,
  input  wire logic        I_SPECIAL_TRIG,
  output logic             O_TIMER_CLEAR,
  // Analog front end.
  input  wire logic        I_CMP_ABOVE,
  output logic      [7:0]  O_DAC_CODE,
  output logic      [3:0]  O_CHANNEL_SEL,
  output logic             O_SAMPLE,
  output logic             O_CONV_ENABLE,
  // Interrupt.
  output logic             O_IRQ
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.

  actc_ctrl_s  ctrl_reg, ctrl_next;       // Main converter control.
  logic [2:0]  pcfg_reg, pcfg_next;       // Pin analog configuration.
  logic [5:0]  dir_reg, dir_next;         // Port direction, 1 is input.
  logic [5:0]  latch_reg, latch_next;     // Port output latch.
  logic [7:0]  intc_reg, intc_next;       // Interrupt control storage.
  logic [7:0]  flags_reg, flags_next;     // Sticky event flags.
  logic [7:0]  en_reg, en_next;           // Flag enables (mask).
  logic [7:0]  result_reg, result_next;   // Last conversion result.
  logic [31:0] rdata_reg, rdata_next;     // Read data for the access phase.
  logic        tclr_reg;                  // Timer clear pulse.
  logic        irq_reg;                   // Interrupt level.
  logic [5:0]  pin_s1_reg, pin_s2_reg;    // Port pin synchroniser.
  logic [9:0]  idx;                       // Register index from address.
  logic        mapped;                    // Address hits a register.
  logic        setup;                     // APB setup phase.
  logic        wr;                        // Write taken this cycle.
  actc_ctrl_s  wctrl;                     // Write data as control layout.
  logic [3:0]  analog_mask;               // Pins AN3..AN0 that are analog.
  logic        trig_mode;                 // Compare unit asks for trigger.
  logic        trig_start;                // Trigger starts a conversion.
  logic        sw_start;                  // Software starts a conversion.
  logic        sw_abort;                  // Software stops a conversion.
  logic        seq_busy;                  // Sequencer converting.
  logic        seq_done;                  // Sequencer finished, one cycle.
  logic [7:0]  seq_code;                  // Trial or final code.
  logic        half_tick;                 // Half conversion-clock period.

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode.

  // Registers are one word each; the index is the word address.
  assign idx   = I_PADDR[11:2];
  assign setup = I_PSEL && !I_PENABLE;
  assign wctrl = actc_ctrl_s'(I_PWDATA[7:0]);

  // Address decode shared by read and write.
  always_comb
  begin
    unique case (idx)
      `ACTC_IDX_PORT_A_PINS, `ACTC_IDX_INTERRUPT_CONTROL,
      `ACTC_IDX_PERIPH_FLAGS_ONE, `ACTC_IDX_CONV_RESULT,
      `ACTC_IDX_CONV_CTRL_MAIN, `ACTC_IDX_PORT_A_DIRECTION,
      `ACTC_IDX_PERIPH_EN_ONE, `ACTC_IDX_CONV_PIN_CONFIG:
        mapped = 1'b1;
      default:
        mapped = 1'b0;
    endcase
  end

  // Zero wait states: the access phase always completes at once, and
  // an unmapped address ends with an error and no side effect.
  assign O_PREADY  = 1'b1;
  assign O_PSLVERR = I_PSEL && I_PENABLE && !mapped;
  assign wr        = I_PSEL && I_PENABLE && I_PWRITE && mapped;
  assign O_PRDATA  = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Pin configuration.

  // Which of AN3..AN0 are analog channels. A reference pin counts as
  // analog here, so it also reads zero in the port register.
  always_comb
  begin
    unique case (pcfg_reg)
      3'h0, 3'h1, 3'h2, 3'h3: analog_mask = 4'hf;
      3'h4, 3'h5:             analog_mask = 4'hb;
      default:                analog_mask = 4'h0;
    endcase
  end

  // The port drives a pin whose direction bit is zero. The converter taps
  // the pin directly, so direction and digital setup never block it.
  assign O_PORT_A    = latch_reg;
  assign O_PORT_A_OE = ~dir_reg;

  // Channel decode; codes with the top bit set select nothing.
  always_comb
  begin
    O_CHANNEL_SEL = 4'h0;
    if (!ctrl_reg.input_channel_select[2])
    begin
      O_CHANNEL_SEL[ctrl_reg.input_channel_select[1:0]] = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Conversion start, stop and trigger.

  // Trigger only counts in the trigger mode and while the converter is on.
  assign trig_mode  = (I_COMPARE_MODE == `ACTC_TRIG_MODE);
  assign trig_start = I_SPECIAL_TRIG && trig_mode
                      && ctrl_reg.converter_on && !seq_busy;

  // A start needs the converter already on before this write; a start in
  // the same write that turns it on is dropped rather than half-honoured.
  assign sw_start = wr && idx == `ACTC_IDX_CONV_CTRL_MAIN && wctrl.go
                    && ctrl_reg.converter_on && wctrl.converter_on
                    && !seq_busy;

  // Clearing go or the enable during a conversion aborts it.
  assign sw_abort = seq_busy && wr && idx == `ACTC_IDX_CONV_CTRL_MAIN
                    && (!wctrl.go || !wctrl.converter_on);

  ////////////////////////////////////////////////////////////////////////////
  // Conversion clock and sequencer.

  // Tick generator runs only during a conversion so the first period is
  // whole for the divided selects; with RC it waits for the next edge.
  actc_tick_gen u_tick (
    .clk       (I_CORE_CLK),
    .rst_n     (I_RST_N),
    .run       (seq_busy),
    .sel       (ctrl_reg.conv_clock_select),
    .rc_osc    (I_RC_OSC),
    .half_tick (half_tick)
  );

  // Sequencer: 19 half periods, bits decided MSB first.
  actc_sar_seq u_sar (
    .clk       (I_CORE_CLK),
    .rst_n     (I_RST_N),
    .start     (sw_start || trig_start),
    .abort     (sw_abort),
    .half_tick (half_tick),
    .cmp_above (I_CMP_ABOVE),
    .busy      (seq_busy),
    .done      (seq_done),
    .code      (seq_code)
  );

  assign O_DAC_CODE    = seq_code;
  assign O_SAMPLE      = ctrl_reg.converter_on && !seq_busy;
  assign O_CONV_ENABLE = ctrl_reg.converter_on;
  assign O_TIMER_CLEAR = tclr_reg;
  assign O_IRQ         = irq_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Register next values.

  // Writes, hardware updates and read data. Hardware sets of flags are
  // applied after the software clear so an event never gets lost.
  always_comb
  begin
    ctrl_next   = ctrl_reg;
    pcfg_next   = pcfg_reg;
    dir_next    = dir_reg;
    latch_next  = latch_reg;
    intc_next   = intc_reg;
    flags_next  = flags_reg;
    en_next     = en_reg;
    result_next = result_reg;
    rdata_next  = rdata_reg;
    // Software writes.
    if (wr)
    begin
      unique case (idx)
        `ACTC_IDX_CONV_CTRL_MAIN:
        begin
          ctrl_next    = wctrl;
          ctrl_next.go = sw_start || (ctrl_reg.go && !sw_abort);
        end
        `ACTC_IDX_CONV_PIN_CONFIG:  pcfg_next  = I_PWDATA[2:0];
        `ACTC_IDX_PORT_A_DIRECTION: dir_next   = I_PWDATA[5:0];
        `ACTC_IDX_PORT_A_PINS:      latch_next = I_PWDATA[5:0];
        `ACTC_IDX_INTERRUPT_CONTROL: intc_next = I_PWDATA[7:0];
        `ACTC_IDX_PERIPH_FLAGS_ONE:
          flags_next = flags_reg & ~I_PWDATA[7:0];
        `ACTC_IDX_PERIPH_EN_ONE:    en_next    = I_PWDATA[7:0];
        default:
        begin
          // The result register ignores writes.
        end
      endcase
    end
    // Trigger sets go like a software start would.
    if (trig_start)
    begin
      ctrl_next.go = 1'b1;
    end
    if (I_SPECIAL_TRIG && trig_mode)
    begin
      flags_next[`ACTC_BIT_TRIG_FLAG] = 1'b1;
    end
    // Completion updates result, go and flag in the same edge.
    if (seq_done)
    begin
      result_next                     = seq_code;
      ctrl_next.go                    = 1'b0;
      flags_next[`ACTC_BIT_DONE_FLAG] = 1'b1;
    end
    // Read data is captured in the setup phase, held for the access.
    if (setup)
    begin
      rdata_next = 32'h0000_0000;
      unique case (idx)
        `ACTC_IDX_PORT_A_PINS:
          rdata_next[5:0] = pin_s2_reg & ~{2'b00, analog_mask};
        `ACTC_IDX_INTERRUPT_CONTROL: rdata_next[7:0] = intc_reg;
        `ACTC_IDX_PERIPH_FLAGS_ONE:  rdata_next[7:0] = flags_reg;
        `ACTC_IDX_CONV_RESULT:       rdata_next[7:0] = result_reg;
        `ACTC_IDX_CONV_CTRL_MAIN:    rdata_next[7:0] = ctrl_reg;
        `ACTC_IDX_PORT_A_DIRECTION:  rdata_next[5:0] = dir_reg;
        `ACTC_IDX_PERIPH_EN_ONE:     rdata_next[7:0] = en_reg;
        `ACTC_IDX_CONV_PIN_CONFIG:   rdata_next[2:0] = pcfg_reg;
        default:
        begin
          // Unmapped reads return zero.
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers.

  // Reset returns controls to their reset values, which turns the
  // converter off; the sequencer aborts on the same reset.
  always_ff @(posedge I_CORE_CLK)
  begin
    if (!I_RST_N)
    begin
      ctrl_reg   <= actc_ctrl_s'(`ACTC_RST_CTRL_MAIN);
      pcfg_reg   <= `ACTC_RST_PIN_CONFIG;
      dir_reg    <= `ACTC_RST_DIRECTION;
      latch_reg  <= `ACTC_RST_PORT_LATCH;
      intc_reg   <= `ACTC_RST_INT_CTRL;
      flags_reg  <= `ACTC_RST_FLAGS;
      en_reg     <= `ACTC_RST_ENABLES;
      result_reg <= `ACTC_RST_RESULT;
      rdata_reg  <= 32'h0000_0000;
      tclr_reg   <= 1'b0;
      irq_reg    <= 1'b0;
      pin_s1_reg <= 6'h00;
      pin_s2_reg <= 6'h00;
    end
    else
    begin
      ctrl_reg   <= ctrl_next;
      pcfg_reg   <= pcfg_next;
      dir_reg    <= dir_next;
      latch_reg  <= latch_next;
      intc_reg   <= intc_next;
      flags_reg  <= flags_next;
      en_reg     <= en_next;
      result_reg <= result_next;
      rdata_reg  <= rdata_next;
      tclr_reg   <= I_SPECIAL_TRIG;
      irq_reg    <= |(flags_next & en_next);
      pin_s1_reg <= I_PORT_A;
      pin_s2_reg <= pin_s1_reg;
    end
  end
endmodule : actc_top

// ### tb_top.sv
// Self-checking bench of the converter control.
// Assumes the front-end model stands in for the analog side.
`timescale 1ns/1ps
`include "actc_defines.svh"
module tb_top;
  logic clk, rst_n, psel, pen, pwr, rc, trig, serr, above;
  logic irq, tclr, samp, cen, rdy, perr;
  logic [11:0] pa;
  logic [31:0] pd, prd, r;
  logic [5:0] pin, pout, poe;
  logic [3:0] mode, chs;
  logic [7:0] code;
  logic [3:0][7:0] lev;
  int miscompares, check_count, cyc, tcnt;
  localparam A_PORT = {`ACTC_IDX_PORT_A_PINS, 2'b00};
  localparam A_FLAG = {`ACTC_IDX_PERIPH_FLAGS_ONE, 2'b00};
  localparam A_RES = {`ACTC_IDX_CONV_RESULT, 2'b00};
  localparam A_CTRL = {`ACTC_IDX_CONV_CTRL_MAIN, 2'b00};
  localparam A_DIR = {`ACTC_IDX_PORT_A_DIRECTION, 2'b00};
  localparam A_EN = {`ACTC_IDX_PERIPH_EN_ONE, 2'b00};
  localparam A_CFG = {`ACTC_IDX_CONV_PIN_CONFIG, 2'b00};

  actc_top u_dut (.I_CORE_CLK(clk), .I_RST_N(rst_n), .I_PSEL(psel),
    .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(pa), .I_PWDATA(pd),
    .O_PRDATA(prd), .O_PREADY(rdy), .O_PSLVERR(perr), .I_PORT_A(pin),
    .O_PORT_A(pout), .O_PORT_A_OE(poe), .I_RC_OSC(rc),
    .I_COMPARE_MODE(mode), .I_SPECIAL_TRIG(trig), .O_TIMER_CLEAR(tclr),
    .I_CMP_ABOVE(above), .O_DAC_CODE(code), .O_CHANNEL_SEL(chs),
    .O_SAMPLE(samp), .O_CONV_ENABLE(cen), .O_IRQ(irq));
  actc_front_model u_fe (.dac_code(code), .chan_sel(chs), .port_out(pout),
    .port_oe(poe), .level(lev), .cmp_above(above), .port_in(pin));
  ////////////////////////////////////////////////////////////////////////
  // RC source, free in phase, 2 us per period.
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial
  begin
    rc = 1'b0;
    forever #1000 rc = ~rc;
  end
  // Timer-clear count and cycle ceiling.
  always @(posedge clk)
  begin
    cyc++;
    if (tclr === 1'b1)
      tcnt++;
    if (cyc == 20000)
    begin
      miscompares++;
      conclude;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : conclude
  task automatic chk(input string nm, input logic [31:0] s, e);
    check_count++;
    if (s !== e)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // One APB transfer; data and error taken at the ready edge.
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr  <= w;
    pa   <= a;
    pd   <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (rdy !== 1'b1);
    r    = prd;
    serr = perr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask : apb
  task automatic rd(input string nm, logic [11:0] a, logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, r, e);
  endtask : rd
  // Polls go, giving up after 1000 reads.
  task automatic wait_done;
    r = 32'h4;
    for (int n = 0; n < 1000 && r[2]; n++)
      apb(1'b0, A_CTRL, 32'h0);
  endtask : wait_done
  // Channel and clock first, go in a later write.
  task automatic conv(input logic [7:0] c);
    apb(1'b1, A_CTRL, {24'h0, c});
    apb(1'b1, A_CTRL, {24'h0, c | 8'h04});
    wait_done;
  endtask : conv
  task automatic fire(input logic [3:0] m);
    mode <= m;
    @(posedge clk);
    trig <= 1'b1;
    @(posedge clk);
    trig <= 1'b0;
  endtask : fire
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    {rst_n, psel, pen, pwr, trig, pa, pd, mode} = '0;
    // Ch 0 full scale: select 00 outruns the sync.
    lev = {8'h3c, 8'h81, 8'hc3, 8'hff};
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd("ctrl", A_CTRL, 32'h0);
    rd("dir", A_DIR, 32'h3f);
    rd("cfg", A_CFG, 32'h0);
    rd("unmapped", 12'h100, 32'h0);
    chk("slverr", serr, 32'h1);
    apb(1'b1, A_CTRL, 32'h04);
    rd("go off", A_CTRL, 32'h0);
    apb(1'b1, A_CTRL, 32'h05);
    rd("go same", A_CTRL, 32'h1);
    apb(1'b1, A_EN, 32'h40);
    // Every clock select, each on its own channel.
    for (int s = 0; s < 4; s++)
    begin
      conv({s[1:0], s[2:0], 3'b001});
      rd("result", A_RES, {24'h0, lev[s]});
      rd("flags", A_FLAG, 32'h40);
      chk("irq", irq, 32'h1);
      apb(1'b1, A_FLAG, 32'h40);
      repeat (2) @(posedge clk);
      chk("irq clr", irq, 32'h0);
    end
    apb(1'b1, A_EN, 32'h0);
    conv(8'h01);
    chk("masked", irq, 32'h0);
    apb(1'b1, A_PORT, 32'h02);
    apb(1'b1, A_DIR, 32'h3d);
    conv(8'h09);
    rd("out pin", A_RES, 32'hff);
    apb(1'b1, A_DIR, 32'h3f);
    rd("analog", A_PORT, 32'h30);
    apb(1'b1, A_CFG, 32'h06);
    rd("digital", A_PORT, 32'h37);
    conv(8'h01);
    rd("dconv", A_RES, 32'hff);
    apb(1'b1, A_FLAG, 32'h44);
    fire(4'hb);
    wait_done;
    rd("tres", A_RES, 32'hff);
    rd("tflags", A_FLAG, 32'h44);
    fire(4'h9);
    rd("no start", A_CTRL, 32'h01);
    apb(1'b1, A_CTRL, 32'h0);
    apb(1'b1, A_FLAG, 32'h44);
    fire(4'hb);
    rd("off ctrl", A_CTRL, 32'h0);
    rd("off flags", A_FLAG, 32'h04);
    chk("tclr", tcnt, 32'h3);
    apb(1'b1, A_CTRL, 32'h81);
    apb(1'b1, A_CTRL, 32'h85);
    rd("busy", A_CTRL, 32'h85);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd("abort", A_CTRL, 32'h0);
    rd("aflag", A_FLAG, 32'h0);
    conclude;
  end
endmodule : tb_top
